// *** inc/tbcc_pkg.sv ***
// package for the time base capture/compare block
// assumes a single 200 mhz clock and an axi4-lite register bus
package tbcc_pkg;
  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFF_MODULE_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RUN_CONTROL    = 8'h04;
  localparam logic [7:0] OFF_CLOCK_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_SOFT_CAPTURE   = 8'h0c;
  localparam logic [7:0] OFF_READ_CAPTURE   = 8'h10;
  localparam logic [7:0] OFF_CAP0_CONTROL   = 8'h14;
  localparam logic [7:0] OFF_CAP0_VALUE     = 8'h18;
  localparam logic [7:0] OFF_CAP1_CONTROL   = 8'h1c;
  localparam logic [7:0] OFF_CAP1_VALUE     = 8'h20;
  localparam logic [7:0] OFF_CMP_CONTROL    = 8'h24;
  localparam logic [7:0] OFF_CMP0_VALUE     = 8'h28;
  localparam logic [7:0] OFF_CMP1_VALUE     = 8'h2c;
  localparam logic [7:0] OFF_GROUP_STATUS   = 8'h30;
  localparam logic [7:0] OFF_GROUP_MASK     = 8'h34;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int MC_ENABLE_BIT   = 7;
  localparam int MC_IDLE_BIT     = 6;
  localparam int RUN_COUNT_BIT   = 0;
  localparam int RUN_PRESC_BIT   = 1;
  localparam int RUN_CLEAR_BIT   = 2;
  localparam int RUN_SCAP_BIT    = 3;
  localparam int CLK_FILTER_BIT  = 4;
  localparam int CAP_FILTER_BIT  = 7;
  localparam int CMP_EN0_BIT     = 0;
  localparam int CMP_BUF0_BIT    = 1;
  localparam int CMP_EN1_BIT     = 4;
  localparam int CMP_BUF1_BIT    = 5;
  localparam logic [3:0] CLK_SEL_PIN = 4'hf;
  localparam logic [1:0] EDGE_OFF    = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] EDGE_BOTH   = 2'h3;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int FILTER_OFF_CYC  = 2;
  localparam int FILTER_ON_CYC   = 6;
  localparam int PRESC_WIDTH     = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic overflow;
    logic cap0;
    logic group;
    logic match0;
    logic match1;
  } irq_t;
endpackage

// *** verilog/pin_filter.sv ***
// pin synchroniser, glitch filter and edge detector for one external input
// assumes the pin is asynchronous to aclk
module pin_filter
  import tbcc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       pin,
  input  wire logic       filter_on,
  output logic            level,
  output logic            rise,
  output logic            fall
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       cand;
    logic [2:0] cnt;
    logic       level;
    logic       rise;
    logic       fall;
  } pf_state_t;

  pf_state_t st;
  pf_state_t next_st;

  // -------------------------------------------------------------------
  // level must hold for the threshold before it is accepted
  // -------------------------------------------------------------------
  always_comb
  begin
    logic [2:0] need;
    need = filter_on ? 3'(FILTER_ON_CYC) : 3'(FILTER_OFF_CYC);
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.s2 != st.cand)
    begin
      next_st.cand = st.s2;
      next_st.cnt = 3'h1;
    end
    else if (st.cnt < need)
      next_st.cnt = st.cnt + 3'h1;
    if (st.s2 == st.cand && st.cnt + 3'h1 >= need && st.level != st.cand)
    begin
      next_st.level = st.cand;
      next_st.rise = st.cand;
      next_st.fall = ~st.cand;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign level = st.level;
  assign rise  = st.rise;
  assign fall  = st.fall;
endmodule // pin_filter

// *** verilog/prescaler.sv ***
// prescaler producing one-cycle tick strobes for divide-by-2 to 256
// assumes the base tick arrives as a one-cycle enable
module prescaler
  import tbcc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       base_tick,
  output logic [7:0]      taps
);
  typedef struct packed {
    logic [PRESC_WIDTH-1:0] cnt;
    logic [7:0]             taps;
  } ps_state_t;

  ps_state_t st;
  ps_state_t next_st;

  // -------------------------------------------------------------------
  // tap i fires when the low i+1 bits roll over
  // -------------------------------------------------------------------
  always_comb
  begin
    logic run_and;
    run_and = 1'b1;
    next_st = st;
    next_st.taps = 8'h00;
    if (!run)
      next_st.cnt = '0;
    else if (base_tick)
    begin
      next_st.cnt = st.cnt + 8'h01;
      // running and of the low bits, no variable-width part-select
      for (int i = 0; i < 8; i++)
      begin
        run_and = run_and & st.cnt[i];
        next_st.taps[i] = run_and;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign taps = st.taps;
endmodule // prescaler

// *** verilog/timebase_capture_compare32.sv ***
// 32-bit time base counter with two captures and two compares
// assumes an axi4-lite master on aclk and asynchronous pins
//
// Functional notes
// - prescaler taps divide base clock by 2 through 256, software picks one
// - run bit 1 starts prescaler, 0 clears and halts it
// - 32-bit counter increments once per selected clock rising edge
// - select codes 0-7 pick taps, code f picks external clock pin
// - after reset counter is zero and idle
// - overflow raises interrupt, count wraps to zero and continues
// - full-word read of read-capture register captures live count
// - software chooses count, stop holding value, or clear
// - writing soft capture bit copies count into soft capture register
// - filter off accepts levels longer than two clocks
// - filter on rejects levels shorter than six clocks
// - each capture detects rise, fall or both; code 00 disables
// - capture event loads count and raises channel interrupt
// - capture 1 grouped with status and mask at bit 0; capture 0 separate
// - capture register is not updated while being read
// - enabled compare channel signals match when value equals count
// - buffer bit set moves buffer into compare on match
// - compare undefined at reset; buffer enable bits reset to zero
// - compare and buffer share address; buffering decides which is written
// - module enable off freezes registers and blocks other accesses
// - unused control bits read as zero
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
module timebase_capture_compare32
  import tbcc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       base_tick,
  input  wire logic       external_count_clock_pin,
  input  wire logic [1:0] capture_trigger_pin,
  input  wire axil_req_t  req,
  output axil_rsp_t       rsp,
  output irq_t            irq,
  output logic [1:0]      compare_match
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_READ = 3'b100
  } bus_state_t;

  typedef struct packed {
    bus_state_t  wst;
    bus_state_t  rst;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        module_enable;
    logic        idle_mode_control;
    logic        counter_run;
    logic        prescaler_run_bit;
    logic [3:0]  count_clock_select;
    logic        clock_pin_filter_enable;
    logic [31:0] count;
    logic [31:0] soft_capture;
    logic [31:0] read_capture;
    logic [1:0][1:0]  capture_edge_select;
    logic [1:0]       trigger_pin_filter_enable;
    logic [1:0][31:0] capture_value;
    logic [1:0]       compare_enable_bits;
    logic [1:0]       compare_buffer_enable;
    logic [1:0][31:0] compare_value_reg;
    logic [1:0][31:0] compare_buffer;
    logic [2:0]  grouped_irq_status;
    logic [2:0]  grouped_irq_mask;
    irq_t        irq;
    logic [1:0]  match;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic [7:0] taps;
  logic       ext_rise;
  logic [1:0] trig_rise;
  logic [1:0] trig_fall;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        m[b*8 +: 8] = data[b*8 +: 8];
    return m;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFF_GROUP_MASK;
  endfunction

  // -------------------------------------------------------------------
  // sub blocks
  // -------------------------------------------------------------------
  prescaler u_prescaler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce && st.module_enable),
    .run       (st.prescaler_run_bit),
    .base_tick (base_tick),
    .taps      (taps)
  );

  pin_filter u_clk_filter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce && st.module_enable),
    .pin       (external_count_clock_pin),
    .filter_on (st.clock_pin_filter_enable),
    .level     (),
    .rise      (ext_rise),
    .fall      ()
  );

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_trig
      pin_filter u_trig_filter (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce && st.module_enable),
        .pin       (capture_trigger_pin[g]),
        .filter_on (st.trigger_pin_filter_enable[g]),
        .level     (),
        .rise      (trig_rise[g]),
        .fall      (trig_fall[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    logic        tick;
    logic        do_write;
    logic        do_read;
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic [31:0] wd;
    logic [1:0]  cap_evt;
    logic [1:0]  reading_cap;
    logic        gated;
    tick = 1'b0;
    do_write = 1'b0;
    do_read = 1'b0;
    wa = st.aw_addr;
    ra = req.araddr;
    wd = 32'h0;
    cap_evt = 2'h0;
    reading_cap = 2'h0;
    gated = 1'b0;
    next_st = st;
    next_st.irq = '0;
    next_st.match = 2'h0;

    // bus write channel
    if (!st.aw_held && req.awvalid)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = req.awaddr;
    end
    if (!st.w_held && req.wvalid)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = req.wdata;
      next_st.w_strb = req.wstrb;
    end
    case (st.wst)
      BUS_IDLE:
        if (st.aw_held && st.w_held)
        begin
          do_write = 1'b1;
          next_st.wst = BUS_RESP;
        end
      BUS_RESP:
        if (req.bready)
        begin
          next_st.wst = BUS_IDLE;
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
        end
      default:
        next_st.wst = BUS_IDLE;
    endcase

    // bus read channel
    case (st.rst)
      BUS_IDLE:
        if (req.arvalid)
        begin
          do_read = 1'b1;
          next_st.rst = BUS_READ;
        end
      BUS_READ:
        if (req.rready)
          next_st.rst = BUS_IDLE;
      default:
        next_st.rst = BUS_IDLE;
    endcase

    // register write
    if (do_write)
    begin
      gated = !st.module_enable && wa != OFF_MODULE_CONTROL;
      next_st.bresp = (is_mapped(wa) && !gated) ? RESP_OKAY : RESP_SLVERR;
      if (!gated)
      begin
        wd = merge_bytes(32'h0, st.w_data, st.w_strb);
        case (wa)
          OFF_MODULE_CONTROL:
            if (st.w_strb[0])
            begin
              next_st.module_enable = wd[MC_ENABLE_BIT];
              next_st.idle_mode_control = wd[MC_IDLE_BIT];
            end
          OFF_RUN_CONTROL:
            if (st.w_strb[0])
            begin
              next_st.counter_run = wd[RUN_COUNT_BIT];
              next_st.prescaler_run_bit = wd[RUN_PRESC_BIT];
              if (wd[RUN_CLEAR_BIT])
                next_st.count = 32'h0;
              if (wd[RUN_SCAP_BIT])
                next_st.soft_capture = st.count;
            end
          OFF_CLOCK_CONTROL:
            if (st.w_strb[0])
            begin
              next_st.count_clock_select = wd[3:0];
              next_st.clock_pin_filter_enable = wd[CLK_FILTER_BIT];
            end
          OFF_CAP0_CONTROL,
          OFF_CAP1_CONTROL:
            if (st.w_strb[0])
            begin
              next_st.capture_edge_select[wa[3]] = wd[1:0];
              next_st.trigger_pin_filter_enable[wa[3]] = wd[CAP_FILTER_BIT];
            end
          OFF_CMP_CONTROL:
            if (st.w_strb[0])
            begin
              next_st.compare_enable_bits = {wd[CMP_EN1_BIT], wd[CMP_EN0_BIT]};
              next_st.compare_buffer_enable = {wd[CMP_BUF1_BIT], wd[CMP_BUF0_BIT]};
            end
          OFF_CMP0_VALUE,
          OFF_CMP1_VALUE:
          begin
            // byte lanes merge so low-to-high byte writes build the word
            next_st.compare_buffer[wa[2]] = merge_bytes(st.compare_buffer[wa[2]], st.w_data,
                                                        st.w_strb);
            if (!st.compare_buffer_enable[wa[2]])
              next_st.compare_value_reg[wa[2]] = merge_bytes(st.compare_buffer[wa[2]], st.w_data,
                                                             st.w_strb);
          end
          OFF_GROUP_MASK:
            if (st.w_strb[0])
              next_st.grouped_irq_mask = wd[2:0];
          default:
            next_st.bresp = RESP_SLVERR;
        endcase
      end
    end

    // register read
    if (do_read)
    begin
      gated = !st.module_enable && ra != OFF_MODULE_CONTROL;
      next_st.rresp = (is_mapped(ra) && !gated) ? RESP_OKAY : RESP_SLVERR;
      next_st.rdata = 32'h0;
      if (!gated)
        case (ra)
          OFF_MODULE_CONTROL:
            next_st.rdata = {24'h0, st.module_enable, st.idle_mode_control, 6'h0};
          OFF_RUN_CONTROL:
            next_st.rdata = {30'h0, st.prescaler_run_bit, st.counter_run};
          OFF_CLOCK_CONTROL:
            next_st.rdata = {27'h0, st.clock_pin_filter_enable, st.count_clock_select};
          OFF_SOFT_CAPTURE:
            next_st.rdata = st.soft_capture;
          OFF_READ_CAPTURE:
            // every axi4-lite read is a full word, so it always captures
            begin
              next_st.read_capture = st.count;
              next_st.rdata = st.count;
            end
          OFF_CAP0_CONTROL,
          OFF_CAP1_CONTROL:
            next_st.rdata = {24'h0, st.trigger_pin_filter_enable[ra[3]], 5'h0,
                             st.capture_edge_select[ra[3]]};
          OFF_CAP0_VALUE,
          OFF_CAP1_VALUE:
          begin
            reading_cap[ra[5]] = 1'b1;
            next_st.rdata = st.capture_value[ra[5]];
          end
          OFF_CMP_CONTROL:
            next_st.rdata = {26'h0, st.compare_buffer_enable[1], st.compare_enable_bits[1], 2'h0,
                             st.compare_buffer_enable[0], st.compare_enable_bits[0]};
          OFF_CMP0_VALUE,
          OFF_CMP1_VALUE:
            next_st.rdata = st.compare_value_reg[ra[2]];
          OFF_GROUP_STATUS:
          begin
            next_st.rdata = {29'h0, st.grouped_irq_status};
            next_st.grouped_irq_status = 3'h0;
          end
          OFF_GROUP_MASK:
            next_st.rdata = {29'h0, st.grouped_irq_mask};
          default:
            next_st.rdata = 32'h0;
        endcase
    end

    // counter
    if (st.module_enable)
    begin
      if (st.count_clock_select == CLK_SEL_PIN)
        tick = ext_rise;
      else if (!st.count_clock_select[3])
        tick = taps[st.count_clock_select[2:0]];
      if (st.counter_run && tick)
      begin
        next_st.count = st.count + 32'h1;
        if (&st.count)
          next_st.irq.overflow = 1'b1;
      end

      // captures
      for (int c = 0; c < 2; c++)
      begin
        case (st.capture_edge_select[c])
          EDGE_RISE: cap_evt[c] = trig_rise[c];
          EDGE_FALL: cap_evt[c] = trig_fall[c];
          EDGE_BOTH: cap_evt[c] = trig_rise[c] | trig_fall[c];
          default:   cap_evt[c] = 1'b0;
        endcase
        if (cap_evt[c] && !reading_cap[c])
          next_st.capture_value[c] = st.count;
      end
      next_st.irq.cap0 = cap_evt[0] && !reading_cap[0];
      if (cap_evt[1] && !reading_cap[1])
        next_st.grouped_irq_status[0] = 1'b1;
      next_st.irq.group = cap_evt[1] && !reading_cap[1] && !st.grouped_irq_mask[0];

      // compares fire on the step onto the value, not while the count rests there
      for (int k = 0; k < 2; k++)
        if (st.compare_enable_bits[k] && st.counter_run && tick && st.compare_value_reg[k] == st.count + 32'h1)
        begin
          next_st.match[k] = 1'b1;
          if (st.compare_buffer_enable[k])
            next_st.compare_value_reg[k] = st.compare_buffer[k];
        end
      next_st.irq.match0 = next_st.match[0];
      next_st.irq.match1 = next_st.match[1];
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.wst <= BUS_IDLE;
      st.rst <= BUS_IDLE;
      st.grouped_irq_mask <= 3'h7;
    end
    else if (ce)
      st <= next_st;
  end

  always_comb
  begin
    rsp.awready = !st.aw_held;
    rsp.wready  = !st.w_held;
    rsp.bvalid  = st.wst == BUS_RESP;
    rsp.bresp   = st.bresp;
    rsp.arready = st.rst == BUS_IDLE;
    rsp.rvalid  = st.rst == BUS_READ;
    rsp.rdata   = st.rdata;
    rsp.rresp   = st.rresp;
  end

  assign irq = st.irq;
  assign compare_match = st.match;
endmodule // timebase_capture_compare32

// *** dv/pin_model.sv ***
// far side pins: external count clock and two capture triggers
// assumes aclk paces every level that is offered
module pin_model
(
  input  wire logic  aclk,
  output logic       clock_pin,
  output logic [1:0] trig
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    clock_pin = 1'b0;
    trig = 2'b00;
  end
  // a level always stands the asked count, never shorter
  task automatic hold_trig(input int ch, input logic lvl, input int n);
    @(posedge aclk);
    trig[ch] <= lvl;
    repeat (n) @(posedge aclk);
  endtask
  // clock pin rests low between bursts
  task automatic clock_pulses(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      clock_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      clock_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule // pin_model

// *** dv/tbcc_checker.sv ***
// port assertions for the capture/compare block
// assumes one aclk domain and a sync active-low reset
module tbcc_checker
  import tbcc_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  input wire logic       base_tick,
  input wire logic       external_count_clock_pin,
  input wire logic [1:0] capture_trigger_pin,
  input wire axil_req_t  req,
  input wire axil_rsp_t  rsp,
  input wire irq_t       irq,
  input wire logic [1:0] compare_match
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_r_wait;
    rsp.rvalid && !req.rready;
  endsequence
  sequence s_b_wait;
    rsp.bvalid && !req.bready;
  endsequence
  chk_ovf_pulse: assert property (irq.overflow |=> !irq.overflow)
    else $error("overflow request too long");
  chk_cap0_pulse: assert property (irq.cap0 |=> !irq.cap0)
    else $error("capture request too long");
  chk_group_pulse: assert property (irq.group |=> !irq.group)
    else $error("group request too long");
  chk_match0_pulse: assert property (compare_match[0] |=> !compare_match[0])
    else $error("match 0 too long");
  chk_match1_pulse: assert property (compare_match[1] |=> !compare_match[1])
    else $error("match 1 too long");
  chk_reset_idle: assert property ($rose(aresetn) |-> irq == '0 && !rsp.bvalid && !rsp.rvalid)
    else $error("outputs busy after reset");
  chk_read_stands: assert property (s_r_wait |=> rsp.rvalid && $stable(rsp.rdata))
    else $error("read answer dropped");
  chk_write_stands: assert property (s_b_wait |=> rsp.bvalid && $stable(rsp.bresp))
    else $error("write answer dropped");
  chk_error_zero: assert property (rsp.rvalid && rsp.rresp == RESP_SLVERR |-> rsp.rdata == '0)
    else $error("refused read not zero");
endmodule // tbcc_checker
bind timebase_capture_compare32 tbcc_checker tbcc_checker_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .base_tick(base_tick), .external_count_clock_pin(external_count_clock_pin),
  .capture_trigger_pin(capture_trigger_pin), .req(req), .rsp(rsp), .irq(irq), .compare_match(compare_match));

// *** dv/testbench.sv ***
// self-checking bench for the capture/compare block
// assumes base_tick every cycle, so tap k divides aclk by 2**(k+1)
module testbench
  import tbcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, ce, base_tick, clock_pin;
  logic [1:0] trig, compare_match;
  axil_req_t req;
  axil_rsp_t rsp;
  irq_t irq;
  logic [31:0] a, d, e;
  logic [1:0] r;
  int checked, n_mismatch, cyc, n_cap0, n_grp, n_m0, n_m1, base, k, seed;
  int code[7] = '{0, 1, 2, 3, 3, 3, 3};
  int filt[7] = '{0, 0, 0, 0, 0, 1, 1};
  int wid[7] = '{8, 8, 8, 8, 4, 4, 10};
  int nexp[7] = '{0, 1, 1, 2, 2, 0, 2};
  timebase_capture_compare32 timebase_capture_compare32_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .base_tick(base_tick), .external_count_clock_pin(clock_pin), .capture_trigger_pin(trig),
    .req(req), .rsp(rsp), .irq(irq), .compare_match(compare_match));
  pin_model pin_model_i (.aclk(aclk), .clock_pin(clock_pin), .trig(trig));
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (irq.cap0 === 1'b1) n_cap0++;
    if (irq.group === 1'b1) n_grp++;
    if (compare_match[0] === 1'b1) n_m0++;
    if (compare_match[1] === 1'b1) n_m1++;
    if (cyc > 30000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= ad;
    req.wvalid <= 1'b1;
    req.wdata <= dt;
    req.wstrb <= s;
    req.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= ad;
    req.rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    dt = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] seen);
    checked++;
    if (seen !== ex)
    begin
      $display("Error %s expected %h seen %h", what, ex, seen);
      n_mismatch++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'h05a887dd;
    ce = 1'b1;
    base_tick = 1'b1;
    req = '0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wr(OFF_RUN_CONTROL, 32'h1, 4'h1);
    chk("run while disabled", RESP_SLVERR, r);
    wr(OFF_MODULE_CONTROL, 32'hff, 4'h1);
    rd(OFF_MODULE_CONTROL, d);
    chk("module_control", 32'hc0, d);
    wr(OFF_CAP0_CONTROL, 32'hff, 4'h1);
    rd(OFF_CAP0_CONTROL, d);
    chk("capture0_control", 32'h83, d);
    rd(8'h3c, d);
    chk("unmapped", RESP_SLVERR, r);
    wr(OFF_RUN_CONTROL, 32'h8, 4'h1);
    rd(OFF_SOFT_CAPTURE, d);
    chk("idle count", 32'h0, d);
    wr(OFF_CLOCK_CONTROL, CLK_SEL_PIN, 4'h1);
    wr(OFF_RUN_CONTROL, 32'h1, 4'h1);
    pin_model_i.clock_pulses(5);
    repeat (8) @(posedge aclk);
    wr(OFF_RUN_CONTROL, 32'h9, 4'h1);
    rd(OFF_SOFT_CAPTURE, d);
    chk("pin clock count", 32'h5, d);
    $display("test setup and pin clock done");
    wr(OFF_RUN_CONTROL, 32'h3, 4'h1);
    for (k = 0; k < 8; k++)
    begin
      wr(OFF_CLOCK_CONTROL, k, 4'h1);
      rd(OFF_READ_CAPTURE, a);
      base = cyc;
      repeat (8 << (k + 1)) @(posedge aclk);
      rd(OFF_READ_CAPTURE, d);
      e = (cyc - base) >> (k + 1);
      chk("tap rate", 32'h1, (d - a - e) <= 1);
    end
    wr(OFF_CLOCK_CONTROL, 32'h0, 4'h1);
    wr(OFF_RUN_CONTROL, 32'h1, 4'h1);
    rd(OFF_READ_CAPTURE, a);
    repeat (40) @(posedge aclk);
    rd(OFF_READ_CAPTURE, d);
    chk("halted prescaler", a, d);
    wr(OFF_RUN_CONTROL, 32'h7, 4'h1);
    rd(OFF_READ_CAPTURE, d);
    chk("cleared count", 32'h1, d < 8);
    $display("test prescaler done");
    for (k = 0; k < 7; k++)
    begin
      wr(OFF_CAP0_CONTROL, code[k] | (filt[k] << 7), 4'h1);
      base = n_cap0;
      pin_model_i.hold_trig(0, 1'b1, wid[k]);
      pin_model_i.hold_trig(0, 1'b0, 20);
      chk("capture events", nexp[k], n_cap0 - base);
    end
    rd(OFF_CAP0_VALUE, a);
    rd(OFF_READ_CAPTURE, d);
    chk("capture value", 32'h1, (d - a) < 64);
    wr(OFF_CAP1_CONTROL, EDGE_RISE, 4'h1);
    base = n_grp;
    pin_model_i.hold_trig(1, 1'b1, 10);
    pin_model_i.hold_trig(1, 1'b0, 10);
    chk("masked group", 32'h0, n_grp - base);
    wr(OFF_GROUP_MASK, 32'h6, 4'h1);
    pin_model_i.hold_trig(1, 1'b1, 10);
    pin_model_i.hold_trig(1, 1'b0, 10);
    chk("group request", 32'h1, n_grp - base);
    rd(OFF_GROUP_STATUS, d);
    chk("group status", 32'h1, d);
    rd(OFF_GROUP_STATUS, d);
    chk("status cleared", 32'h0, d);
    $display("test capture done");
    rd(OFF_READ_CAPTURE, a);
    e = a + 60 + ($random(seed) & 15);
    for (k = 0; k < 4; k++) wr(OFF_CMP0_VALUE, e, 4'h1 << k);
    for (k = 0; k < 4; k++) wr(OFF_CMP1_VALUE, e + 50, 4'h1 << k);
    wr(OFF_CMP_CONTROL, 32'h13, 4'h1);
    for (k = 0; k < 4; k++) wr(OFF_CMP0_VALUE, e + 100, 4'h1 << k);
    base = n_m0;
    repeat (400) @(posedge aclk);
    chk("compare matches", 32'h2, n_m0 - base);
    chk("compare 1 match", 32'h1, n_m1);
    $display("test compare done");
    tally_and_finish();
  end
endmodule // testbench
